// ### hdl/tmc_regs.vh
// How it works
// RULE1: buffered bit set gives one 16-bit access; clear gives two byte accesses
// RULE2: source field 1x both units, 01 second only, 00 neither use us
// RULE3: prescale code 11 1:8, 10 1:4, 01 1:2, 00 1:1
// RULE4: external source: sync-disable 1 skips synchroniser stage, 0 uses it
// RULE5: source 0 counts every cycle; 1 counts edges after first fall
// RULE6: on bit enables counting; clearing it halts and keeps the count
// RULE7: timer, synchronous counter and asynchronous counter modes exist
// RULE8: oscillator enabled forces both port pins to input, reads zero
// RULE9: buffered mode: low byte read copies live high byte to buffer
// RULE10: buffered mode: low byte write loads buffer into live high byte
// RULE11: buffered mode: high byte address reaches only the buffer
// RULE12: low byte write clears prescaler; high byte write leaves it
// RULE13: software sets oscillator enable and source select to use oscillator
// RULE14: count wraps from all ones to zero and sets overflow flag
// RULE15: overflow flag sticky; interrupt only when enable bit 1 set
// RULE16: compare mode 1011 on our unit resets count, may start conversion
// RULE17: software avoids asynchronous mode when relying on trigger resets
// RULE18: count write in trigger cycle wins; the trigger's count reset is dropped, its conversion start still fires
// RULE19: second unit trigger resets count without setting overflow flag
// RULE20: reset clears control, prescaler and high byte buffer
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
`define TMC_OFS_CTRL 12'h000
`define TMC_OFS_LOW 12'h004
`define TMC_OFS_HIGH 12'h008
`define TMC_OFS_FLAGS 12'h00C
`define TMC_OFS_ENABLES 12'h010
`define TMC_OFS_PRIOS 12'h014
`define TMC_BIT_BUF16 7
`define TMC_BIT_SRC_HI 6
`define TMC_BIT_PRE_HI 5
`define TMC_BIT_PRE_LO 4
`define TMC_BIT_SRC_LO 3
`define TMC_BIT_NOSYNC 2
`define TMC_BIT_CLKSEL 1
`define TMC_BIT_ON 0
`define TMC_BIT_OVF 1
`define TMC_CTRL_RST 8'h00
`define TMC_BYTE_RST 8'h00
`define TMC_PRE_RST 3'h0
`define TMC_MODE_TRIG 4'hB
`define TMC_CNT_MAX 16'hFFFF
`define TMC_CNT_ZERO 16'h0000
`define TMC_TRANS_NSEQ_BIT 1
`define TMC_RESP_OKAY 1'b0
`define TMC_WORD_ZERO 32'h00000000
`endif

// ### hdl/tmc_timer.v
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "tmc_regs.vh"
module tmc_timer #(
  parameter ADDR_W = 12,
  parameter PRE_W = 3
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire external_count_input,
  input wire lowpower_osc_clk,
  input wire lowpower_osc_enable,
  input wire [3:0] first_compare_mode,
  input wire [3:0] second_compare_mode,
  input wire first_compare_match,
  input wire second_compare_match,
  input wire adc_enable,
  output reg adc_start,
  output reg first_unit_uses_this,
  output reg second_unit_uses_this,
  input wire [1:0] port_direction_bits,
  input wire [1:0] port_pin_in,
  output reg [1:0] port_pin_oe,
  output reg [1:0] port_read,
  output reg overflow_irq,
  output reg overflow_irq_high
);

  // 1:2^sel divide: tick when the low sel bits are all ones
  function pre_done;
    input [PRE_W-1:0] cnt;
    input [1:0] sel;
    reg [PRE_W-1:0] mask;
    begin
      mask = ~({PRE_W{1'b1}} << sel);
      pre_done = ((cnt & mask) == mask);
    end
  endfunction

  function sel_is;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      sel_is = (a == ofs);
    end
  endfunction

  reg [7:0] counter_control;
  reg [7:0] count_low_byte;
  reg [7:0] count_high_byte;
  reg [7:0] high_buffer;
  reg overflow_flag;
  reg overflow_irq_enable;
  reg overflow_irq_priority;
  reg [PRE_W-1:0] prescale_cnt;

  reg ext_s1;
  reg ext_s2;
  reg osc_s1;
  reg osc_s2;
  reg [1:0] pin_s1;
  reg [1:0] pin_s2;
  reg src_d1;
  reg src_prev;
  reg armed;

  reg dp_wr;
  reg dp_rd;
  reg rd_wait;
  reg [ADDR_W-1:0] dp_addr;

  wire buffered_access_enable = counter_control[`TMC_BIT_BUF16];
  wire compare_source_sel_hi = counter_control[`TMC_BIT_SRC_HI];
  wire compare_source_sel_lo = counter_control[`TMC_BIT_SRC_LO];
  wire [1:0] input_prescale_sel =
    counter_control[`TMC_BIT_PRE_HI:`TMC_BIT_PRE_LO];
  wire ext_sync_disable = counter_control[`TMC_BIT_NOSYNC];
  wire clock_source_sel = counter_control[`TMC_BIT_CLKSEL];
  wire counter_on = counter_control[`TMC_BIT_ON];

  assign hresp = `TMC_RESP_OKAY;

  // address phase accepted only while the bus is ready
  wire addr_take = hsel & htrans[`TMC_TRANS_NSEQ_BIT] & hready;

  wire wr_ctrl = dp_wr & sel_is(dp_addr, `TMC_OFS_CTRL);
  wire wr_low = dp_wr & sel_is(dp_addr, `TMC_OFS_LOW);
  wire wr_high = dp_wr & sel_is(dp_addr, `TMC_OFS_HIGH);
  wire wr_flags = dp_wr & sel_is(dp_addr, `TMC_OFS_FLAGS);
  wire wr_en = dp_wr & sel_is(dp_addr, `TMC_OFS_ENABLES);
  wire wr_prio = dp_wr & sel_is(dp_addr, `TMC_OFS_PRIOS);
  wire rd_low = dp_rd & rd_wait & sel_is(dp_addr, `TMC_OFS_LOW);

  // any write that touches the live count this cycle
  wire count_write = wr_low | (wr_high & ~buffered_access_enable);

  // routing of this timer to the compare units
  wire first_uses = compare_source_sel_hi; // RULE2
  wire second_uses = compare_source_sel_hi | compare_source_sel_lo; // RULE2

  // external source: oscillator when enabled, else the count pin
  wire src_raw = lowpower_osc_enable ? osc_s2 : ext_s2; // RULE7 RULE13
  // sync mode adds a stage that mirrors the sampling latency
  wire src_now = ext_sync_disable ? src_raw : src_d1; // RULE4
  wire src_rise = src_now & ~src_prev;
  wire src_fall = ~src_now & src_prev;

  wire count_clk = clock_source_sel ? (src_rise & armed) : 1'b1; // RULE5
  wire count_tick = counter_on & count_clk; // RULE6
  wire count_inc = count_tick &
    pre_done(prescale_cnt, input_prescale_sel); // RULE3

  wire first_trig = first_compare_match & first_uses &
    (first_compare_mode == `TMC_MODE_TRIG); // RULE16
  wire second_trig = second_compare_match & second_uses &
    (second_compare_mode == `TMC_MODE_TRIG); // RULE16
  // a write in the same cycle beats the trigger
  wire trig_reset = (first_trig | second_trig) & ~count_write; // RULE18

  wire [15:0] count_now = {count_high_byte, count_low_byte};
  wire [15:0] count_next = count_now + 16'h0001;
  wire wrap = count_inc & (count_now == `TMC_CNT_MAX); // RULE14

  // pin synchronisers, first stage read only by the second
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
    end else begin
      ext_s1 <= external_count_input;
      ext_s2 <= ext_s1;
      osc_s1 <= lowpower_osc_clk;
      osc_s2 <= osc_s1;
      pin_s1 <= port_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // edge detection and the first-falling-edge arm
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_d1 <= 1'b0;
      src_prev <= 1'b0;
      armed <= 1'b0;
    end else begin
      src_d1 <= src_raw;
      src_prev <= src_now;
      if (!counter_on || !clock_source_sel) begin
        armed <= 1'b0;
      end else if (src_fall) begin
        armed <= 1'b1; // RULE5
      end
    end
  end

  // bus data phase tracking; reads take one wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      rd_wait <= 1'b0;
      dp_addr <= {ADDR_W{1'b0}};
    end else begin
      if (addr_take) begin
        dp_wr <= hwrite;
        dp_rd <= ~hwrite;
        rd_wait <= ~hwrite;
        dp_addr <= haddr[ADDR_W-1:0];
      end else if (hready) begin
        dp_wr <= 1'b0;
        dp_rd <= 1'b0;
        rd_wait <= 1'b0;
      end else begin
        rd_wait <= 1'b0;
      end
    end
  end

  always @* begin
    hreadyout = ~(dp_rd & rd_wait);
  end

  // read data is sampled after any write of the previous cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `TMC_WORD_ZERO;
    end else if (dp_rd & rd_wait) begin
      hrdata <= `TMC_WORD_ZERO;
      case (dp_addr)
        `TMC_OFS_CTRL: begin
          hrdata[7:0] <= counter_control;
        end
        `TMC_OFS_LOW: begin
          hrdata[7:0] <= count_low_byte;
        end
        `TMC_OFS_HIGH: begin
          if (buffered_access_enable) begin
            hrdata[7:0] <= high_buffer; // RULE11
          end else begin
            hrdata[7:0] <= count_high_byte; // RULE1
          end
        end
        `TMC_OFS_FLAGS: begin
          hrdata[`TMC_BIT_OVF] <= overflow_flag;
        end
        `TMC_OFS_ENABLES: begin
          hrdata[`TMC_BIT_OVF] <= overflow_irq_enable;
        end
        `TMC_OFS_PRIOS: begin
          hrdata[`TMC_BIT_OVF] <= overflow_irq_priority;
        end
        default: begin
          hrdata <= `TMC_WORD_ZERO;
        end
      endcase
    end
  end

  // control and interrupt configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_control <= `TMC_CTRL_RST; // RULE20
      overflow_irq_enable <= 1'b0;
      overflow_irq_priority <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        counter_control <= hwdata[7:0];
      end
      if (wr_en) begin
        overflow_irq_enable <= hwdata[`TMC_BIT_OVF];
      end
      if (wr_prio) begin
        overflow_irq_priority <= hwdata[`TMC_BIT_OVF];
      end
    end
  end

  // overflow flag: writing 0 clears, a wrap in that cycle wins
  reg next_overflow_flag;
  always @* begin
    next_overflow_flag = overflow_flag;
    if (wrap & ~count_write & ~trig_reset) begin
      next_overflow_flag = 1'b1; // RULE14 RULE19
    end else if (wr_flags & ~hwdata[`TMC_BIT_OVF]) begin
      next_overflow_flag = 1'b0; // RULE15
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= next_overflow_flag;
    end
  end

  // prescaler: low byte writes and trigger resets restart the divide
  reg [PRE_W-1:0] next_prescale;
  always @* begin
    next_prescale = prescale_cnt;
    if (wr_low) begin
      next_prescale = `TMC_PRE_RST; // RULE12
    end else if (trig_reset) begin
      next_prescale = `TMC_PRE_RST;
    end else if (count_tick) begin
      next_prescale = prescale_cnt + {{(PRE_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_cnt <= `TMC_PRE_RST; // RULE20
    end else begin
      prescale_cnt <= next_prescale;
    end
  end

  // high byte buffer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_buffer <= `TMC_BYTE_RST; // RULE20
    end else if (buffered_access_enable) begin
      if (wr_high) begin
        high_buffer <= hwdata[7:0]; // RULE11
      end else if (rd_low) begin
        high_buffer <= count_high_byte; // RULE9
      end
    end
  end

  // the count pair; writes beat triggers, triggers beat counting
  reg [7:0] next_count_low;
  reg [7:0] next_count_high;
  always @* begin
    next_count_low = count_low_byte;
    next_count_high = count_high_byte;
    if (count_write) begin
      if (wr_low) begin
        next_count_low = hwdata[7:0]; // RULE1
        if (buffered_access_enable) begin
          next_count_high = high_buffer; // RULE10
        end
      end else begin
        next_count_high = hwdata[7:0]; // RULE1
      end
    end else if (trig_reset) begin
      next_count_low = `TMC_BYTE_RST; // RULE16
      next_count_high = `TMC_BYTE_RST;
    end else if (count_inc) begin
      next_count_low = count_next[7:0]; // RULE14
      next_count_high = count_next[15:8];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_low_byte <= `TMC_BYTE_RST;
      count_high_byte <= `TMC_BYTE_RST;
    end else begin
      count_low_byte <= next_count_low;
      count_high_byte <= next_count_high;
    end
  end

  // routing and conversion start, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_start <= 1'b0;
      first_unit_uses_this <= 1'b0;
      second_unit_uses_this <= 1'b0;
    end else begin
      // only the second unit starts conversions
      adc_start <= second_trig & adc_enable; // RULE16
      first_unit_uses_this <= first_uses; // RULE2
      second_unit_uses_this <= second_uses; // RULE2
    end
  end

  // oscillator pins become inputs and read as zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_pin_oe <= 2'h0;
      port_read <= 2'h0;
    end else if (lowpower_osc_enable) begin
      port_pin_oe <= 2'h0; // RULE8
      port_read <= 2'h0; // RULE8
    end else begin
      port_pin_oe <= ~port_direction_bits;
      port_read <= pin_s2;
    end
  end

  // requests follow the sticky flag, so clearing it drops them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq <= 1'b0;
      overflow_irq_high <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag & overflow_irq_enable; // RULE15
      overflow_irq_high <= overflow_flag & overflow_irq_enable &
        overflow_irq_priority;
    end
  end

endmodule

// ### bench/tmc_timer_asserts.sv
`timescale 1ns/1ns
module tmc_timer_asserts (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire lowpower_osc_enable,
  input wire [3:0] second_compare_mode,
  input wire second_compare_match,
  input wire adc_enable,
  input wire adc_start,
  input wire first_unit_uses_this,
  input wire second_unit_uses_this,
  input wire [1:0] port_pin_oe,
  input wire [1:0] port_read,
  input wire overflow_irq,
  input wire overflow_irq_high
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence taken_s;
    hsel && htrans[1] && hready;
  endsequence
  sequence rd_ans_s;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait:
    assert property (taken_s ##0 !hwrite |=> rd_ans_s)
    else $error("read answer out of step");
  chk_write_fast:
    assert property (taken_s ##0 hwrite |=> hreadyout)
    else $error("write stalled");
  chk_resp_okay:
    assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_rdata_upper:
    assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above byte set");
  chk_route_nest:
    assert property (first_unit_uses_this |-> second_unit_uses_this)
    else $error("first unit routed alone");
  chk_osc_inputs:
    assert property (lowpower_osc_enable [*3] |-> port_pin_oe == 2'h0
      && port_read == 2'h0)
    else $error("oscillator pins not inputs");
  chk_irq_prio:
    assert property (overflow_irq_high |-> overflow_irq)
    else $error("high request without request");
  chk_adc_cause:
    assert property (adc_start |-> $past(second_compare_match)
      && $past(adc_enable) && $past(second_compare_mode) == 4'hB)
    else $error("conversion start without trigger");
endmodule
bind tmc_timer tmc_timer_asserts u_tmc_timer_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata),
  .lowpower_osc_enable(lowpower_osc_enable),
  .second_compare_mode(second_compare_mode),
  .second_compare_match(second_compare_match),
  .adc_enable(adc_enable), .adc_start(adc_start),
  .first_unit_uses_this(first_unit_uses_this),
  .second_unit_uses_this(second_unit_uses_this),
  .port_pin_oe(port_pin_oe), .port_read(port_read),
  .overflow_irq(overflow_irq), .overflow_irq_high(overflow_irq_high)
);

// ### bench/tmc_clk_src.sv
`timescale 1ns/1ns
module tmc_clk_src (
  input wire hclk,
  output reg external_count_input = 1'b0,
  output reg lowpower_osc_clk = 1'b0
);
  // idles low; 4-cycle phases so the synchroniser sees every edge
  task automatic pulses(input int n, input bit osc);
    repeat (2 * n) begin
      repeat (4) @(posedge hclk);
      if (osc) begin
        lowpower_osc_clk <= !lowpower_osc_clk;
      end else begin
        external_count_input <= !external_count_input;
      end
    end
  endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ns
`include "tmc_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg second_compare_match = 1'b0;
  reg first_compare_match = 1'b0;
  reg adc_enable = 1'b1;
  reg lowpower_osc_enable = 1'b0;
  reg [1:0] port_direction_bits = 2'h1;
  reg [1:0] port_pin_in = 2'h3;
  wire hreadyout, first_unit_uses_this, second_unit_uses_this;
  wire overflow_irq, overflow_irq_high, adc_start;
  wire external_count_input, lowpower_osc_clk;
  wire [31:0] hrdata;
  wire [1:0] port_pin_oe, port_read;
  int checked = 0;
  int mismatches = 0;
  reg [7:0] q;
  localparam [11:0] ctl = `TMC_OFS_CTRL, lo = `TMC_OFS_LOW;
  localparam [11:0] hi = `TMC_OFS_HIGH, flg = `TMC_OFS_FLAGS;
  always #4 hclk = ~hclk;
  tmc_clk_src u_tmc_clk_src (.hclk, .external_count_input,
    .lowpower_osc_clk);
  tmc_timer u_tmc_timer (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(),
    .hrdata, .external_count_input, .lowpower_osc_clk,
    .lowpower_osc_enable, .first_compare_mode(4'hB),
    .second_compare_mode(4'hB), .first_compare_match,
    .second_compare_match, .adc_enable, .adc_start,
    .first_unit_uses_this, .second_unit_uses_this, .port_direction_bits,
    .port_pin_in, .port_pin_oe, .port_read, .overflow_irq,
    .overflow_irq_high);
  // ready and read data taken at the rising edge, before the slave
  // updates its registers there
  task automatic bus(input bit w, input [11:0] a, input [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task automatic wr(input [11:0] a, input [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input [11:0] a, input [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic t_reset;
    rdc(ctl, `TMC_CTRL_RST);
    rdc(hi, `TMC_BYTE_RST);
    rdc(12'h040, 8'h00);
  endtask
  task automatic t_prescale;
    for (int c = 0; c < 4; c++) begin
      wr(lo, 8'h00);
      wr(ctl, {2'b00, c[1:0], 4'h1});
      repeat ((16 << c) - 2) @(posedge hclk);
      wr(ctl, 8'h00);
      rdc(lo, 8'h10);
      repeat (9) @(posedge hclk);
      rdc(lo, 8'h10);
    end
  endtask
  task automatic t_overflow;
    wr(12'h014, 8'h02);
    wr(12'h010, 8'h02);
    wr(hi, 8'hFF);
    wr(lo, 8'hFE);
    wr(ctl, 8'h01);
    repeat (2) @(posedge hclk);
    wr(ctl, 8'h00);
    rdc(lo, 8'h02);
    rdc(hi, 8'h00);
    rdc(flg, 8'h02);
    `CHK(overflow_irq_high, 1'b1)
    wr(12'h010, 8'h00);
    rdc(flg, 8'h02);
    `CHK(overflow_irq, 1'b0)
    wr(flg, 8'h00);
    rdc(flg, 8'h00);
  endtask
  task automatic t_buffer;
    wr(hi, 8'h34);
    wr(ctl, 8'h80);
    wr(hi, 8'h12);
    rdc(hi, 8'h12);
    rdc(lo, 8'h02);
    rdc(hi, 8'h34);
    wr(hi, 8'h56);
    wr(lo, 8'h78);
    wr(ctl, 8'h00);
    rdc(hi, 8'h56);
    rdc(lo, 8'h78);
  endtask
  task automatic t_trigger;
    reg [7:0] s;
    for (int i = 0; i < 3; i++) begin
      s = i == 0 ? 8'h40 : i == 1 ? 8'h08 : 8'h00;
      adc_enable <= (i != 1);
      wr(ctl, s);
      wr(hi, 8'h12);
      wr(lo, 8'h34);
      `CHK(first_unit_uses_this, s[6])
      `CHK(second_unit_uses_this, s[6] | s[3])
      second_compare_match <= 1'b1;
      @(posedge hclk);
      second_compare_match <= 1'b0;
      @(posedge hclk);
      `CHK(adc_start, s[6])
      rdc(lo, s == 0 ? 8'h34 : 8'h00);
      rdc(hi, s == 0 ? 8'h12 : 8'h00);
    end
    rdc(flg, 8'h00);
    wr(ctl, 8'h40);
    fork
      wr(lo, 8'h55);
      begin
        @(posedge hclk);
        second_compare_match <= 1'b1;
        @(posedge hclk);
        second_compare_match <= 1'b0;
      end
    join
    rdc(lo, 8'h55);
    rdc(hi, 8'h12);
    first_compare_match <= 1'b1;
    @(posedge hclk);
    first_compare_match <= 1'b0;
    rdc(lo, 8'h00);
    rdc(hi, 8'h00);
  endtask
  task automatic t_external;
    for (int k = 0; k < 3; k++) begin
      lowpower_osc_enable <= k == 2;
      wr(lo, 8'h00);
      wr(ctl, k == 1 ? 8'h07 : 8'h03);
      u_tmc_clk_src.pulses(5, k == 2);
      repeat (8) @(posedge hclk);
      wr(ctl, 8'h00);
      rdc(lo, 8'h04);
    end
    `CHK(port_pin_oe, 2'b00)
    `CHK(port_read, 2'b00)
    lowpower_osc_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    `CHK(port_pin_oe, 2'b10)
    `CHK(port_read, 2'b11)
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_prescale();
    t_overflow();
    t_buffer();
    t_trigger();
    t_external();
    stop_test();
  end
  // whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    stop_test();
  end
endmodule
